// *** dv/sbgt_pin_src.sv ***
/* Count pin source: a burst of rising edges on request, else the gate level.
   Assumes requests only while idle; each edge is two cycles high, two low. */
`timescale 1ns/1ps
module sbgt_pin_src (
    input wire logic aclk, // System clock
    input wire logic go, // Start a burst
    input wire logic [7:0] n_edges, // Edges in the burst
    input wire logic gate, // Level outside bursts
    output logic pin // Count pin
);
    logic [7:0] left = 8'h00;
    logic [1:0] ph = 2'h0;
    initial pin = 1'h0;
    always @(posedge aclk) begin
        if (left != 8'h00) begin
            pin <= (ph < 2'h2);
            ph <= ph + 2'h1;
            if (ph == 2'h3) left <= left - 8'h01;
        end else begin
            pin <= gate;
            ph <= 2'h0;
            if (go) left <= n_edges;
        end
    end
endmodule

// *** dv/sbgt_sva.sv ***
/* Port checks of the gated timer: bus answers, reset and interrupt level.
   Assumes the single clock aclk and the synchronous active-low aresetn. */
`timescale 1ns/1ps
module sbgt_sva
    import sbgt_pkg::*;
(
    input wire logic aclk, // System clock
    input wire logic aresetn, // Reset, active low
    input wire logic awvalid, // Write address valid
    input wire logic awready, // Write address ready
    input wire logic wvalid, // Write data valid
    input wire logic wready, // Write data ready
    input wire logic [1:0] bresp, // Write response
    input wire logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic arvalid, // Read address valid
    input wire logic arready, // Read address ready
    input wire logic [31:0] rdata, // Read data
    input wire logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    input wire logic irq, // Interrupt level
    input wire logic [PRIO_W-1:0] timer_irq_priority // Priority
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped early");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped early");
    rd_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    wr_answer_a: assert property (awvalid && awready && wvalid && wready |=> bvalid)
        else $error("write answer late");
    ar_block_a: assert property (rvalid |-> !arready)
        else $error("read taken while answer pending");
    aw_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while answer pending");
    prio_write_a: assert property ($changed(timer_irq_priority) |-> $rose(bvalid))
        else $error("priority moved without a write");
    irq_clear_a: assert property ($fell(irq) |-> $past(bvalid))
        else $error("interrupt fell without a write");
    reset_quiet_a: assert property ($rose(aresetn) |-> !bvalid && !rvalid && !irq)
        else $error("outputs busy after reset");
    cover property ($rose(irq));
    cover property (bvalid && bresp == RESP_SLVERR);
    cover property (rvalid && rready);
endmodule

bind sbgt_timer sbgt_sva sbgt_sva_i (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
    .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .irq,
    .timer_irq_priority);

// *** dv/tb.sv ***
/* Self-checking bench of the gated timer: AXI4-Lite master tasks, queued
   expectations checked by a monitor, and the count pin source.
   Assumes a 10 MHz aclk and the register map of sbgt_pkg. */
`timescale 1ns/1ps
module tb;
    import sbgt_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, idle_mode = 0;
    logic bready = 1, rready = 1, go = 0, gate = 0, irq, awready, wready, bvalid, arready;
    logic rvalid, pin;
    logic [7:0] awaddr = 0, araddr = 0, n_edges = 0;
    logic [31:0] wdata = 0, rdata, seed = 32'h24088478, p, h, cyc = 0, t0;
    logic [3:0] wstrb = 0;
    logic [1:0] bresp, rresp;
    logic [2:0] prio;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [15:0] rv[6] = '{CTRL_RESET, PERIOD_RESET, COUNT_RESET, 16'h0, 16'h0, 16'h0};
    int ps[4] = '{1, 8, 64, 256};
    int failures = 0, checks = 0;
    sbgt_timer sbgt_timer_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .external_count_pin(pin), .idle_mode, .irq,
        .timer_irq_priority(prio));
    sbgt_pin_src sbgt_pin_src_i (.aclk, .go, .n_edges, .gate, .pin);
    always #50 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task complete_run;
        if (failures == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task cmp_word(input logic [33:0] g, input logic [33:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    task cmp_resp(input logic [1:0] g, input logic [1:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t response %h want %h", $time, g, e);
        end
    endtask
    // Bounded waits: a hang is a mismatch, not a stall
    task lim(input int k);
        if (k >= 30000) begin
            failures++;
            complete_run;
        end
    endtask
    always @(posedge aclk) begin
        if (bvalid && bready) cmp_resp(bresp, bq.pop_front());
        if (rvalid && rready) cmp_word({rresp, rdata}, rq.pop_front());
    end
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
        int k;
        bq.push_back(e);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 0;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (k == 2) bready <= 1;
        end while (!(bvalid && bready) && k < 30000);
        lim(k);
    endtask
    task rd(input logic [7:0] a, input logic [33:0] e);
        int k;
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1;
        rready <= 0;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
            if (arready) arvalid <= 0;
            if (k == 2) rready <= 1;
        end while (!(rvalid && rready) && k < 30000);
        lim(k);
    endtask
    task wirq(input logic v);
        int k;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
        end while (irq !== v && k < 30000);
        lim(k);
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        for (int i = 0; i < 6; i++) rd(8'(i * 4), {18'h0, rv[i]});
        wr(REG_TIMER_CONTROL, 32'hFFFF);
        rd(REG_TIMER_CONTROL, {18'h0, CTRL_IMPL_MASK});
        wr(REG_TIMER_CONTROL, 32'h0);
        wr(8'h18, 32'h1, RESP_SLVERR);
        rd(8'h18, {RESP_SLVERR, 32'h0});
        wr(REG_IRQ_PRIORITY, 32'hFFFF_FFFF);
        rd(REG_IRQ_PRIORITY, 34'h7);
        cmp_word({31'h0, prio}, 34'h7);
        p = 20 + xs() % 31;
        wr(REG_PERIOD, p);
        wr(REG_IRQ_MASK, 32'h1);
        for (int c = 0; c < 4; c++) begin
            wr(REG_TIMER_CONTROL, 32'h8000 | (c << 4));
            wr(REG_COUNT, 32'h0);
            wr(REG_IRQ_STATUS, 32'h1);
            wirq(0);
            wirq(1);
            t0 = cyc;
            wr(REG_IRQ_STATUS, 32'h1);
            wirq(0);
            wirq(1);
            cmp_word(cyc - t0, ps[c] * (p + 1));
        end
        idle_mode <= 1;
        wr(REG_TIMER_CONTROL, 32'hA000);
        wr(REG_COUNT, 32'h5);
        repeat (20) @(posedge aclk);
        rd(REG_COUNT, 34'h5);
        wr(REG_TIMER_CONTROL, 32'h8000);
        wr(REG_IRQ_STATUS, 32'h1);
        wirq(0);
        wirq(1);
        rd(REG_IRQ_STATUS, 34'h1);
        idle_mode <= 0;
        wr(REG_TIMER_CONTROL, 32'h0);
        wr(REG_COUNT, 32'h7);
        repeat (20) @(posedge aclk);
        rd(REG_COUNT, 34'h7);
        wr(REG_PERIOD, 32'hFFFF);
        // Gate bit stays set here: it must be ignored with the pin as clock
        for (int s = 0; s < 2; s++) begin
            wr(REG_TIMER_CONTROL, 32'h0042 | (s << 2));
            wr(REG_COUNT, 32'h0);
            wr(REG_TIMER_CONTROL, 32'h8042 | (s << 2));
            n_edges <= 8'(3 + xs() % 8);
            go <= 1;
            @(posedge aclk);
            go <= 0;
            repeat (n_edges * 4 + 12) @(posedge aclk);
            rd(REG_COUNT, {26'h0, n_edges});
        end
        h = 8 + xs() % 20;
        wr(REG_TIMER_CONTROL, 32'h0040);
        wr(REG_COUNT, 32'h0);
        wr(REG_IRQ_MASK, 32'h2);
        wr(REG_IRQ_STATUS, 32'h3);
        wr(REG_TIMER_CONTROL, 32'h8040);
        gate <= 1;
        repeat (h) @(posedge aclk);
        gate <= 0;
        wirq(1);
        rd(REG_COUNT, {2'h0, h});
        rd(REG_IRQ_STATUS, 34'h2);
        wr(REG_IRQ_MASK, 32'h0);
        repeat (2) @(posedge aclk);
        cmp_word({33'h0, irq}, 34'h0);
        complete_run;
    end
endmodule

// *** logic/sbgt_link_if.sv ***
/*
 * Internal carrier between the timer core, the pin conditioner and the
 * prescaler. All signals live in the aclk domain.
 */
`timescale 1ns/1ps
interface sbgt_link_if;
    logic ext_rise_sync;
    logic ext_rise_async;
    logic gate_level;
    logic gate_fall;
    logic count_in;
    logic ps_clear;
    logic [1:0] ps_sel;
    logic tick;

    modport cond (output ext_rise_sync, output ext_rise_async, output gate_level,
                  output gate_fall);
    modport pres (input count_in, input ps_clear, input ps_sel, output tick);
    modport core (input ext_rise_sync, input ext_rise_async, input gate_level,
                  input gate_fall, input tick, output count_in, output ps_clear,
                  output ps_sel);
endinterface

// *** logic/sbgt_pin_cond.sv ***
/*
 * Conditions the external count pin: a synchronised rising edge, an
 * unsynchronised rising edge, the gate level and the gate falling edge.
 * Assumes the pin is sampled by aclk; the sync path adds two cycles.
 */
`timescale 1ns/1ps
module sbgt_pin_cond (
    input wire logic aclk,               // System clock
    input wire logic aresetn,            // Synchronous reset, active low
    input wire logic external_count_pin, // Count clock or gate pin
    sbgt_link_if.cond lk                 // Conditioned pin events
);
    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic raw_q;

    // ------------------------------------------------------------------
    // Sampling
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
            raw_q <= 1'b0;
        end else begin
            sync_a <= external_count_pin;
            sync_b <= sync_a;
            sync_c <= sync_b;
            raw_q <= external_count_pin;
        end
    end

    // R7: two paths offered
    // Unsynchronised path reacts two cycles sooner but trusts the pin timing
    assign lk.ext_rise_async = external_count_pin & ~raw_q;
    assign lk.ext_rise_sync = sync_b & ~sync_c;
    // R15: gate level and fall
    assign lk.gate_level = sync_b;
    assign lk.gate_fall = ~sync_b & sync_c;
endmodule

// *** logic/sbgt_pkg.sv ***
/*
 * Shared constants of the sixteen bit gated timer: register offsets,
 * control field positions, reset values, prescale codes and bus answers.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package sbgt_pkg;

    // ------------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_TIMER_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_PERIOD = 8'h04;
    localparam logic [ADDR_W-1:0] REG_COUNT = 8'h08;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h10;
    localparam logic [ADDR_W-1:0] REG_IRQ_PRIORITY = 8'h14;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_RUN_BIT = 15;
    localparam int CTRL_IDLE_STOP_BIT = 13;
    localparam int CTRL_GATE_BIT = 6;
    localparam int CTRL_PS_LSB = 4;
    localparam int CTRL_SYNC_BIT = 2;
    localparam int CTRL_SRC_BIT = 1;
    localparam logic [15:0] CTRL_IMPL_MASK = 16'hA076;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // Other reset values and widths
    // ------------------------------------------------------------------
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam int IRQ_W = 2;
    localparam int IRQ_MATCH_BIT = 0;
    localparam int IRQ_GATE_BIT = 1;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
    localparam int PRIO_W = 3;
    localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;

    // ------------------------------------------------------------------
    // Prescale codes and last count of each ratio
    // ------------------------------------------------------------------
    localparam logic [1:0] PS_DIV1 = 2'h0;
    localparam logic [1:0] PS_DIV8 = 2'h1;
    localparam logic [1:0] PS_DIV64 = 2'h2;
    localparam logic [1:0] PS_DIV256 = 2'h3;
    localparam logic [7:0] PS_LAST_DIV1 = 8'h00;
    localparam logic [7:0] PS_LAST_DIV8 = 8'h07;
    localparam logic [7:0] PS_LAST_DIV64 = 8'h3F;
    localparam logic [7:0] PS_LAST_DIV256 = 8'hFF;

    // ------------------------------------------------------------------
    // AXI answers
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** logic/sbgt_prescaler.sv ***
/*
 * Divides count events by 1, 8, 64 or 256 and emits one tick per group.
 * Assumes the core clears it whenever counting is stopped or reloaded.
 */
`timescale 1ns/1ps
module sbgt_prescaler
    import sbgt_pkg::*;
#(
    parameter int PS_W = 8 // Width of the divider count
) (
    input wire logic aclk,    // System clock
    input wire logic aresetn, // Synchronous reset, active low
    sbgt_link_if.pres lk      // Count events in, ticks out
);
    logic [PS_W-1:0] div_cnt;
    logic [PS_W-1:0] div_last;

    // R6: ratio from select
    always_comb begin
        unique case (lk.ps_sel)
            PS_DIV1: div_last = PS_W'(PS_LAST_DIV1);
            PS_DIV8: div_last = PS_W'(PS_LAST_DIV8);
            PS_DIV64: div_last = PS_W'(PS_LAST_DIV64);
            PS_DIV256: div_last = PS_W'(PS_LAST_DIV256);
        endcase
    end

    assign lk.tick = lk.count_in & ~lk.ps_clear & (div_cnt == div_last);

    always_ff @(posedge aclk) begin
        if (!aresetn || lk.ps_clear) begin
            div_cnt <= '0;
        end else if (lk.count_in) begin
            div_cnt <= (div_cnt == div_last) ? '0 : div_cnt + PS_W'(1);
        end
    end
endmodule

// *** logic/sbgt_timer.sv ***
/*
 * Sixteen bit gated timer: AXI4-Lite register slave, counter with period
 * match, gated accumulation, idle stop and a masked interrupt output.
 * Assumes a single clock aclk; the count pin is sampled on aclk.
 */
// Functional notes
// R1: The counter is 16 bits and runs as timer, synchronous or unsynchronised edge counter.
// R2: An interrupt is raised on period match and, in gated mode, on the gate falling edge.
// R3: Control bit 15 starts the counter when one and stops it when zero.
// R4: Control bit 13 halts the module in idle mode when set; when clear counting goes on.
// R5: Control bit 6 counts internal clocks only while the gate is high; ignored on pin clock.
// R6: Control bits 5-4 divide the count clock by 256, 64, 8 or 1 for codes 11, 10, 01, 00.
// R7: Control bit 2 picks synchronised or raw pin edges and is ignored on the internal clock.
// R8: Control bit 1 picks rising count pin edges when set and the internal clock when clear.
// R9: Control bits 14, 12 to 7, 3 and 0 ignore writes and read as zero.
// R10: All implemented control bits clear at reset: stopped, undivided, ungated, internal clock.
// R11: Software sets the modes and loads the 16-bit period register.
// R12: Software sets the interrupt enable and a three-bit priority for the timer.
// R13: The timer serves as a free-running interval timer or counter and as a real-time clock.
// R14: A prescaled tick adds one, or zeroes the count and flags when it equals the period.
// R15: In gated mode internal ticks count only while the gate is high and the gate fall flags.
`timescale 1ns/1ps
module sbgt_timer
    import sbgt_pkg::*;
#(
    parameter int PS_W = 8 // Prescaler divider width
) (
    input wire logic aclk,                     // System clock, 10 MHz
    input wire logic aresetn,                  // Synchronous reset, active low
    input wire logic [ADDR_W-1:0] awaddr,      // Write address
    input wire logic awvalid,                  // Write address valid
    output logic awready,                      // Write address ready
    input wire logic [31:0] wdata,             // Write data
    input wire logic [3:0] wstrb,              // Write byte strobes
    input wire logic wvalid,                   // Write data valid
    output logic wready,                       // Write data ready
    output logic [1:0] bresp,                  // Write response
    output logic bvalid,                       // Write response valid
    input wire logic bready,                   // Write response ready
    input wire logic [ADDR_W-1:0] araddr,      // Read address
    input wire logic arvalid,                  // Read address valid
    output logic arready,                      // Read address ready
    output logic [31:0] rdata,                 // Read data
    output logic [1:0] rresp,                  // Read response
    output logic rvalid,                       // Read data valid
    input wire logic rready,                   // Read data ready
    input wire logic external_count_pin,       // Count clock or gate input
    input wire logic idle_mode,                // Device is in idle mode
    output logic irq,                          // Interrupt request, level
    output logic [PRIO_W-1:0] timer_irq_priority // Interrupt priority
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    sbgt_link_if lk ();

    logic [15:0] timer_control;
    logic [15:0] period_register;
    logic [15:0] count;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] timer_irq_enable;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic aw_held;
    logic w_held;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic do_write;
    logic next_aw_held;
    logic next_w_held;
    logic next_bvalid;
    logic next_rvalid;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic rd_hit;
    logic [31:0] rd_val;
    logic ctrl_wr;
    logic period_wr;
    logic count_wr;
    logic status_wr;
    logic mask_wr;
    logic prio_wr;
    logic timer_run;
    logic idle_stop_select;
    logic gate_accum_enable;
    logic ext_clock_sync_select;
    logic clock_source_select;
    logic running;
    logic gated;
    logic period_match;
    logic gate_event;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] next_irq_status;

    function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
        merge16 = {strb[1] ? data[15:8] : old_val[15:8],
                   strb[0] ? data[7:0] : old_val[7:0]};
    endfunction

    // ------------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------------
    sbgt_pin_cond u_pin_cond (
        .aclk(aclk),
        .aresetn(aresetn),
        .external_count_pin(external_count_pin),
        .lk(lk.cond)
    );

    sbgt_prescaler #(
        .PS_W(PS_W)
    ) u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .lk(lk.pres)
    );

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    // Address and data may arrive in either order; each is held until both
    // are present, and only one write is in flight at a time.
    assign aw_take = awvalid & awready;
    assign w_take = wvalid & wready;
    assign do_write = (aw_held | aw_take) & (w_held | w_take) & ~bvalid;
    assign next_aw_held = (aw_held | aw_take) & ~do_write;
    assign next_w_held = (w_held | w_take) & ~do_write;
    assign next_bvalid = do_write | (bvalid & ~bready);
    assign wr_addr = aw_take ? awaddr : aw_addr_q;
    assign wr_data = w_take ? wdata : w_data_q;
    assign wr_strb = w_take ? wstrb : w_strb_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            if (aw_take) begin
                aw_addr_q <= awaddr;
            end
            if (w_take) begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            awready <= ~next_aw_held & ~next_bvalid;
            wready <= ~next_w_held & ~next_bvalid;
            bvalid <= next_bvalid;
            if (do_write) begin
                bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_comb begin
        wr_hit = 1'b1;
        case (wr_addr)
            REG_TIMER_CONTROL, REG_PERIOD, REG_COUNT,
            REG_IRQ_STATUS, REG_IRQ_MASK, REG_IRQ_PRIORITY: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    assign ctrl_wr = do_write & (wr_addr == REG_TIMER_CONTROL);
    assign period_wr = do_write & (wr_addr == REG_PERIOD);
    assign count_wr = do_write & (wr_addr == REG_COUNT);
    assign status_wr = do_write & (wr_addr == REG_IRQ_STATUS);
    assign mask_wr = do_write & (wr_addr == REG_IRQ_MASK);
    assign prio_wr = do_write & (wr_addr == REG_IRQ_PRIORITY);

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    assign ar_take = arvalid & arready;
    assign next_rvalid = ar_take | (rvalid & ~rready);

    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h00000000;
        case (araddr)
            // R9: unused bits read zero
            REG_TIMER_CONTROL: rd_val = {16'h0000, timer_control & CTRL_IMPL_MASK};
            REG_PERIOD: rd_val = {16'h0000, period_register};
            REG_COUNT: rd_val = {16'h0000, count};
            REG_IRQ_STATUS: rd_val = 32'(irq_status);
            REG_IRQ_MASK: rd_val = 32'(timer_irq_enable);
            REG_IRQ_PRIORITY: rd_val = 32'(timer_irq_priority);
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else begin
            arready <= ~next_rvalid;
            rvalid <= next_rvalid;
            if (ar_take) begin
                rdata <= rd_val;
                rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // R10: all control bits clear
            timer_control <= CTRL_RESET;
        end else if (ctrl_wr) begin
            // R9: unused bits dropped
            timer_control <= merge16(timer_control, wr_data, wr_strb) & CTRL_IMPL_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_register <= PERIOD_RESET;
        end else if (period_wr) begin
            // R11: software loads period
            period_register <= merge16(period_register, wr_data, wr_strb);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_irq_enable <= IRQ_RESET;
            timer_irq_priority <= PRIO_RESET;
        end else begin
            // R12: enable and priority
            if (mask_wr && wr_strb[0]) begin
                timer_irq_enable <= wr_data[IRQ_W-1:0];
            end
            if (prio_wr && wr_strb[0]) begin
                timer_irq_priority <= wr_data[PRIO_W-1:0];
            end
        end
    end

    assign timer_run = timer_control[CTRL_RUN_BIT];
    assign idle_stop_select = timer_control[CTRL_IDLE_STOP_BIT];
    assign gate_accum_enable = timer_control[CTRL_GATE_BIT];
    assign ext_clock_sync_select = timer_control[CTRL_SYNC_BIT];
    assign clock_source_select = timer_control[CTRL_SRC_BIT];

    // ------------------------------------------------------------------
    // Count source selection
    // ------------------------------------------------------------------
    // R3: run bit starts and stops
    // R4: idle stop halts module
    assign running = timer_run & ~(idle_stop_select & idle_mode);
    // R5: gate only with internal clock
    assign gated = gate_accum_enable & ~clock_source_select;

    // R8: external edge or internal clock
    // R7: sync choice on external source
    // R15: internal ticks while gate high
    assign lk.count_in = running & (clock_source_select ?
        (ext_clock_sync_select ? lk.ext_rise_sync : lk.ext_rise_async) :
        (~gated | lk.gate_level));
    // R6: prescaler code routed
    assign lk.ps_sel = timer_control[CTRL_PS_LSB +: 2];
    // Restarting the divider on reload keeps the first period exact
    assign lk.ps_clear = ~running | ctrl_wr | count_wr;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // R14: match on tick
    assign period_match = lk.tick & (count == period_register);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= COUNT_RESET;
        end else if (count_wr) begin
            count <= merge16(count, wr_data, wr_strb);
        end else if (lk.tick) begin
            // R1: 16-bit count
            // R13: free-running wrap
            // R14: advance or wrap
            count <= period_match ? COUNT_RESET : count + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------
    // R15: gate fall event
    assign gate_event = running & gated & lk.gate_fall;
    // R2: match and gate events
    assign irq_set = {gate_event, period_match};
    assign irq_clr = (status_wr && wr_strb[0]) ? wr_data[IRQ_W-1:0] : IRQ_RESET;
    // A new event in the clearing cycle survives the clear
    assign next_irq_status = (irq_status & ~irq_clr) | irq_set;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= IRQ_RESET;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            // R2: masked request out
            irq <= |(irq_status & timer_irq_enable);
        end
    end

endmodule
